/* File: logic/tbi_serdes_core.v */
// Bit-rate core: serializer, comma aligner, byte clocks and test logic
// Function
// R1 - Misaligned comma shifts the word boundary
// R2 - Realignment only stretches byte clocks
// R3 - Alignment off gives unframed words
// R4 - Comma flag pulses one word with comma
// R5 - Receive latency 21 to 31 bits
// R6 - Loopback feeds transmit stream to receiver
// R7 - Serial output released during loopback
// R8 - Enable low idles all logic
// R9 - Test mode transmits sequence, ignores word
// R10 - Test mode checks sequence, low on error
// R11 - Alignment off: pass shows current result
// R12 - Alignment on: one error latches low
// R13 - Capture word on reference edge, bit0 first
// R14 - Reference clock 60 to 130 MHz
// R15 - Earliest received bit on word bit0
// R16 - Half rate: even words b, odd a
// R17 - Full rate: only clock a toggles
// R18 - Rate select picks half or full clocks
// R19 - Byte clocks re-phased on realignment
// R20 - Comma is pattern 0011111 in stream
// R21 - Comma pulses only with alignment enabled
// R22 - Half-rate clocks 180 degrees apart
// R23 - One word shifted per reference period; code shifts one bit per clock, one word per ten clocks
// R24 - Sequence polynomial x^7 + x^6 + 1
`timescale 1ns/1ns
`default_nettype none
`include "tbi_serdes_defs.vh"
module tbi_serdes_core #(
    parameter RX_DELAY = `RX_DELAY_BITS
) (
    // Clock and reset
    input  wire                  i_clk,
    input  wire                  i_sys_rst,
    // Control pins
    input  wire                  i_enable,
    input  wire                  i_align_enable,
    input  wire                  i_loopback_enable,
    input  wire                  i_prbs_test_enable,
    input  wire                  i_rx_clock_rate_select,
    // Transmit side
    input  wire [`WORD_BITS-1:0] i_tx_parallel_word,
    output reg                   o_serial_out_pair,
    output reg                   o_serial_out_pair_oe,
    // Receive side
    input  wire                  i_serial_in_pair,
    output reg  [`WORD_BITS-1:0] o_rx_parallel_word,
    output reg                   o_rx_byte_clock_a,
    output reg                   o_rx_byte_clock_b,
    output reg                   o_rx_outputs_oe,
    output reg                   o_comma_found_or_prbs_pass
);
    // Word boundary decode shared by both directions
    function is_last;
        input [3:0] cnt;
        begin
            is_last = (cnt == `WORD_LAST);
        end
    endfunction

    // Comma pattern in the earliest seven bits of a word
    function is_comma;
        input [`WORD_BITS-1:0] w;
        begin
            is_comma = (w[`COMMA_BITS-1:0] == `COMMA_PATTERN); // R20
        end
    endfunction

    // Pin synchronisers: index 0 serial in, then the five control pins
    wire [`CTRL_BITS-1:0] pin_raw;
    wire [`CTRL_BITS-1:0] pin_sync;

    assign pin_raw = {i_rx_clock_rate_select, i_prbs_test_enable, i_loopback_enable,
                      i_align_enable, i_enable, i_serial_in_pair};

    genvar g;
    generate
        for (g = 0; g < `CTRL_BITS; g = g + 1) begin : g_sync
            reg meta_q;
            reg sync_q;

            always @(posedge i_clk) begin
                if (i_sys_rst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= pin_raw[g];
                    sync_q <= meta_q;
                end
            end

            assign pin_sync[g] = sync_q;
        end
    endgenerate

    wire ser_in    = pin_sync[0];
    wire en        = pin_sync[1];
    wire align_en  = pin_sync[2];
    wire loop_en   = pin_sync[3];
    wire prbs_en   = pin_sync[4];
    wire full_rate = pin_sync[5];
    wire idle_rst  = i_sys_rst | ~en; // R8

    // Transmit: word capture and serializer
    reg  [3:0]            tx_cnt_q;
    reg  [3:0]            tx_cnt_d;
    reg  [`WORD_BITS-1:0] tx_hold_q;
    reg  [`WORD_BITS-1:0] tx_hold_d;
    reg  [`WORD_BITS-1:0] tx_sr_q;
    reg  [`WORD_BITS-1:0] tx_sr_d;

    wire                  tx_last;
    wire                  gen_bit;
    wire                  tx_bit;

    assign tx_last = is_last(tx_cnt_q);

    prbs7_lane u_gen (
        .i_clk     (i_clk),
        .i_sys_rst (idle_rst),
        .i_check   (1'b0),
        .i_bit     (1'b0),
        .o_bit     (gen_bit),
        .o_error   ()
    ); // R24

    assign tx_bit = prbs_en ? gen_bit : tx_sr_q[0]; // R9

    // Word counter, one bit per clock, wraps after ten clocks per word
    always @* begin
        if (tx_last) begin
            tx_cnt_d = 4'h0;
        end else begin
            tx_cnt_d = tx_cnt_q + 4'h1; // R23
        end
    end

    // Capture a word each period, load the previous one into the shifter
    always @* begin
        tx_hold_d = tx_hold_q;
        if (tx_last) begin
            tx_hold_d = i_tx_parallel_word; // R13
            tx_sr_d   = tx_hold_q;
        end else begin
            tx_sr_d = {1'b0, tx_sr_q[`WORD_BITS-1:1]}; // R13
        end
    end

    // Transmit state
    always @(posedge i_clk) begin
        if (idle_rst) begin
            tx_cnt_q  <= 4'h0;
            tx_hold_q <= {`WORD_BITS{1'b0}};
            tx_sr_q   <= {`WORD_BITS{1'b0}};
        end else begin
            tx_cnt_q  <= tx_cnt_d;
            tx_hold_q <= tx_hold_d;
            tx_sr_q   <= tx_sr_d;
        end
    end

    // Serial pin and its enable
    always @(posedge i_clk) begin
        if (idle_rst) begin
            o_serial_out_pair    <= 1'b0;
            o_serial_out_pair_oe <= 1'b0;
        end else begin
            o_serial_out_pair    <= tx_bit;
            o_serial_out_pair_oe <= ~loop_en; // R7
        end
    end

    // Receive: input select and fixed latency line
    wire                rx_in;
    wire                rx_bit;
    reg  [RX_DELAY-1:0] dly_q;

    assign rx_in  = loop_en ? tx_bit : ser_in; // R6
    assign rx_bit = dly_q[RX_DELAY-1];

    always @(posedge i_clk) begin
        if (idle_rst) begin
            dly_q <= {RX_DELAY{1'b0}};
        end else begin
            dly_q <= {dly_q[RX_DELAY-2:0], rx_in}; // R5
        end
    end

    // Sequence checker on the delayed receive stream
    wire chk_err;

    prbs7_lane u_chk (
        .i_clk     (i_clk),
        .i_sys_rst (idle_rst),
        .i_check   (prbs_en),
        .i_bit     (rx_bit),
        .o_bit     (),
        .o_error   (chk_err)
    ); // R10

    // Deserializer and aligner
    reg  [`WORD_BITS-1:0] rx_sr_q;
    reg  [3:0]            rx_cnt_q;
    reg                   err_word_q;
    reg                   err_latch_q;
    reg                   odd_word_q;

    // Next-state values
    reg  [3:0]            rx_cnt_d;
    reg                   err_word_d;
    reg                   err_latch_d;
    reg                   odd_word_d;
    reg  [`WORD_BITS-1:0] word_d;
    reg                   flag_d;
    reg                   clk_a_d;
    reg                   clk_b_d;

    wire [`WORD_BITS-1:0] rx_next;
    wire                  at_bound;
    wire                  realign;
    wire                  word_err;
    wire                  word_out;

    assign rx_next  = {rx_bit, rx_sr_q[`WORD_BITS-1:1]}; // R15
    assign at_bound = is_last(rx_cnt_q);
    assign realign  = align_en & ~prbs_en & ~at_bound & is_comma(rx_next); // R1
    assign word_err = err_word_q | chk_err;
    assign word_out = at_bound & ~realign;

    // Word counter: a misaligned comma restarts the count
    always @* begin
        if (realign) begin
            rx_cnt_d = 4'h0; // R1
        end else if (at_bound) begin
            rx_cnt_d = 4'h0;
        end else begin
            rx_cnt_d = rx_cnt_q + 4'h1;
        end
    end

    // Error tracking; the clear on exit wins over a new error, clear only on exit
    always @* begin
        err_latch_d = err_latch_q;
        if (!prbs_en) begin
            err_latch_d = 1'b0;
        end else if (word_err & align_en) begin
            err_latch_d = 1'b1; // R12
        end
        err_word_d = word_out ? 1'b0 : word_err;
    end

    // Word, flag and parity at each word boundary
    always @* begin
        word_d     = o_rx_parallel_word;
        flag_d     = o_comma_found_or_prbs_pass;
        odd_word_d = odd_word_q;
        if (word_out) begin
            word_d     = rx_next; // R3
            odd_word_d = ~odd_word_q;
            if (prbs_en && align_en) begin
                flag_d = ~(word_err | err_latch_q); // R12
            end else if (prbs_en) begin
                flag_d = ~word_err; // R11
            end else begin
                flag_d = align_en & is_comma(rx_next); // R4 R21
            end
        end
    end

    // Byte clocks: realign restarts the count, so levels hold and only stretch
    always @* begin
        clk_a_d = o_rx_byte_clock_a;
        clk_b_d = o_rx_byte_clock_b;
        if (word_out) begin
            if (full_rate) begin
                clk_a_d = 1'b1; // R17
                clk_b_d = 1'b0; // R18
            end else begin
                clk_a_d = odd_word_q;  // R16
                clk_b_d = ~odd_word_q; // R22
            end
        end else begin
            if (full_rate && rx_cnt_q == `HALF_WORD && !realign) begin
                clk_a_d = 1'b0; // R2 R19
            end
            if (full_rate) begin
                clk_b_d = 1'b0; // R18
            end
        end
    end

    // Aligner state
    always @(posedge i_clk) begin
        if (idle_rst) begin
            rx_sr_q     <= {`WORD_BITS{1'b0}};
            rx_cnt_q    <= 4'h0;
            err_word_q  <= 1'b0;
            err_latch_q <= 1'b0;
            odd_word_q  <= 1'b0;
        end else begin
            rx_sr_q     <= rx_next;
            rx_cnt_q    <= rx_cnt_d;
            err_word_q  <= err_word_d;
            err_latch_q <= err_latch_d;
            odd_word_q  <= odd_word_d;
        end
    end

    // Receive word and flag pins
    always @(posedge i_clk) begin
        if (idle_rst) begin
            o_rx_parallel_word         <= {`WORD_BITS{1'b0}};
            o_comma_found_or_prbs_pass <= 1'b0;
        end else begin
            o_rx_parallel_word         <= word_d;
            o_comma_found_or_prbs_pass <= flag_d;
        end
    end

    // Byte clock pins
    always @(posedge i_clk) begin
        if (idle_rst) begin
            o_rx_byte_clock_a <= 1'b0;
            o_rx_byte_clock_b <= 1'b0;
        end else begin
            o_rx_byte_clock_a <= clk_a_d;
            o_rx_byte_clock_b <= clk_b_d;
        end
    end

    // Receive outputs are released while idle
    always @(posedge i_clk) begin
        if (idle_rst) begin
            o_rx_outputs_oe <= 1'b0;
        end else begin
            o_rx_outputs_oe <= 1'b1; // R8
        end
    end
endmodule // tbi_serdes_core
`default_nettype wire

/* File: logic/tbi_serdes_defs.vh */
// Constants for the ten-bit-interface serializer core
`ifndef TBI_SERDES_DEFS_VH
`define TBI_SERDES_DEFS_VH
`define WORD_BITS      10
`define WORD_LAST      4'h9
`define HALF_WORD      4'h4
`define COMMA_BITS     7
`define COMMA_PATTERN  7'h7c
`define RX_DELAY_BITS  10
`define PRBS_STAGES    7
`define PRBS_TAP_A     6
`define PRBS_TAP_B     5
`define PRBS_SEED      7'h7f
`define CTRL_BITS      6
`endif

/* File: logic/prbs7_lane.v */
// Seven-stage pseudorandom generator or self-synchronising checker
`timescale 1ns/1ns
`default_nettype none
`include "tbi_serdes_defs.vh"
module prbs7_lane (
    // Clock and reset
    input  wire i_clk,
    input  wire i_sys_rst,
    // Mode and data
    input  wire i_check,
    input  wire i_bit,
    output reg  o_bit,
    output reg  o_error
);
    reg  [`PRBS_STAGES-1:0] state_q;
    wire                    fb;
    wire                    shift_in;

    assign fb       = state_q[`PRBS_TAP_A] ^ state_q[`PRBS_TAP_B];
    assign shift_in = i_check ? i_bit : fb;

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= `PRBS_SEED;
            o_bit   <= 1'b0;
            o_error <= 1'b0;
        end else begin
            state_q <= {state_q[`PRBS_STAGES-2:0], shift_in};
            o_bit   <= fb;
            o_error <= i_check & (i_bit ^ fb);
        end
    end
endmodule // prbs7_lane
`default_nettype wire

/* File: bench/tbi_line_model.sv */
// Serial line model: echoes the transmit stream, can corrupt one bit
`timescale 1ns/1ns
`default_nettype none
module tbi_line_model (
    // Line side
    input  wire logic i_clk,
    input  wire logic i_tx_bit,
    input  wire logic i_tx_oe,
    input  wire logic i_flip,
    output var  logic o_rx_bit = 1'b0
);
    always @(posedge i_clk) begin
        if (i_tx_oe) o_rx_bit <= i_tx_bit ^ i_flip;
        else o_rx_bit <= ~o_rx_bit; // Released line shows no stale level
    end
endmodule // tbi_line_model
`default_nettype wire

/* File: bench/tbi_serdes_core_sva.sv */
// Pin-level assertions for the serializer core
`timescale 1ns/1ns
`default_nettype none
module tbi_serdes_core_sva (
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_enable,
    input wire logic       i_align_enable,
    input wire logic       i_loopback_enable,
    input wire logic       i_prbs_test_enable,
    input wire logic       i_rx_clock_rate_select,
    input wire logic       o_serial_out_pair_oe,
    input wire logic [9:0] o_rx_parallel_word,
    input wire logic       o_rx_byte_clock_a,
    input wire logic       o_rx_byte_clock_b,
    input wire logic       o_rx_outputs_oe,
    input wire logic       o_comma_found_or_prbs_pass
);
    logic [5:0] run_q = 6'h00, hold_q = 6'h00;
    logic       a_q = 1'b0;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    always @(posedge i_clk) begin
        a_q <= o_rx_byte_clock_a;
        run_q <= (i_sys_rst || !i_enable) ? 6'h00 : run_q + {5'h00, ~&run_q};
        hold_q <= (run_q == 6'h00 || o_rx_byte_clock_a != a_q) ? 6'h00 : hold_q + 6'h01;
    end
    sequence s_word_high; o_comma_found_or_prbs_pass[*8] ##1 o_comma_found_or_prbs_pass[*2]; endsequence
    sequence s_comma_rise; (!i_prbs_test_enable)[*4] ##0 $rose(o_comma_found_or_prbs_pass); endsequence
    sequence s_quiet; (!i_align_enable && !i_prbs_test_enable)[*8]; endsequence
    property p_oe_loop; i_loopback_enable[*4] |-> !o_serial_out_pair_oe; endproperty
    property p_oe_drive; (i_enable && !i_loopback_enable)[*4] |-> o_serial_out_pair_oe; endproperty
    property p_idle; (!i_enable)[*4] |-> !o_rx_outputs_oe && !o_serial_out_pair_oe
        && !o_rx_byte_clock_a && !o_rx_byte_clock_b && o_rx_parallel_word == 10'h000; endproperty
    property p_b_low; i_rx_clock_rate_select[*4] |-> !o_rx_byte_clock_b; endproperty
    property p_comma_len; s_comma_rise |-> s_word_high; endproperty
    property p_no_comma; s_quiet ##1 s_quiet |-> !o_comma_found_or_prbs_pass; endproperty
    property p_no_sliver; disable iff (i_sys_rst || !i_enable)
        $rose(o_rx_byte_clock_a) |-> o_rx_byte_clock_a[*5]; endproperty
    property p_stretch; run_q == 6'h3f |-> hold_q < 6'h1e; endproperty
    property p_half; run_q == 6'h3f && !i_rx_clock_rate_select
        |-> o_rx_byte_clock_a != o_rx_byte_clock_b; endproperty
    a_oe_loop: assert property (p_oe_loop) else $error("driving in loopback");
    a_oe_drive: assert property (p_oe_drive) else $error("not driving");
    a_idle: assert property (p_idle) else $error("active while disabled");
    a_b_low: assert property (p_b_low) else $error("clock b runs at full rate");
    a_comma_len: assert property (p_comma_len) else $error("comma pulse short");
    a_no_comma: assert property (p_no_comma) else $error("comma with align off");
    a_no_sliver: assert property (p_no_sliver) else $error("clock a truncated");
    a_stretch: assert property (p_stretch) else $error("clock a stalled");
    a_half: assert property (p_half) else $error("half rate clocks in phase");
endmodule // tbi_serdes_core_sva
bind tbi_serdes_core tbi_serdes_core_sva i_sva (.*);
`default_nettype wire

/* File: bench/tbi_serdes_core_tb.sv */
// Self-checking bench for the serializer core
`timescale 1ns/1ns
`default_nettype none
module tbi_serdes_core_tb;
    logic       clk = 1'b0, rst = 1'b1, en = 1'b1, aln = 1'b1, lpb = 1'b0, prbs = 1'b0;
    logic       rsel = 1'b1, flip = 1'b0, pa = 1'b0, pb = 1'b0, trk = 1'b0, pchk = 1'b0;
    logic       low = 1'b0, plpb = 1'b0, sout, soe, sin, ca, cb, roe, flag;
    logic [9:0] txw = 10'h000, rxw, w;
    logic [6:0] h = 7'h00;
    logic [9:0] sent_q[$];
    int         cyc = 0, err_total = 0, cmp_count = 0, k;
    initial forever #20 clk = ~clk;
    tbi_serdes_core i_dut (.i_clk(clk), .i_sys_rst(rst), .i_enable(en), .i_align_enable(aln),
        .i_loopback_enable(lpb), .i_prbs_test_enable(prbs), .i_rx_clock_rate_select(rsel),
        .i_tx_parallel_word(txw), .o_serial_out_pair(sout), .o_serial_out_pair_oe(soe),
        .i_serial_in_pair(sin), .o_rx_parallel_word(rxw), .o_rx_byte_clock_a(ca),
        .o_rx_byte_clock_b(cb), .o_rx_outputs_oe(roe), .o_comma_found_or_prbs_pass(flag));
    tbi_line_model i_line (.i_clk(clk), .i_tx_bit(sout), .i_tx_oe(soe), .i_flip(flip),
        .o_rx_bit(sin));
    task check(input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task step(input int n, input string s);
        repeat (n) @(posedge clk);
        $display("test %s ends", s);
    endtask
    function logic nxt(input logic [6:0] v);
        return v[6] ^ v[5];
    endfunction
    always @(posedge clk) begin
        cyc <= rst ? 0 : cyc + 1;
        if (cyc % 10 == 5) begin
            w = (cyc % 100 == 5) ? 10'h17c : 10'($urandom) & 10'h2db;
            txw <= w;
            sent_q.push_back(w);
        end
    end
    always @(posedge clk) begin
        pa <= ca;
        pb <= cb;
        plpb <= lpb;
        h <= {h[5:0], sout};
        if (prbs && pchk) check({9'h000, sout}, {9'h000, nxt(h)});
        if (pchk && !flag) low <= 1'b1;
        if (rst || !aln || prbs || lpb !== plpb) trk <= 1'b0;
        else if ((ca && !pa) || (cb && !pb)) begin
            if (flag) begin
                for (k = sent_q.size() - 1; k > 0 && sent_q[k] !== 10'h17c; k--);
                repeat (k) void'(sent_q.pop_front());
                trk <= 1'b1;
            end
            if (flag || trk) check(rxw, sent_q.pop_front());
        end
    end
    initial begin
        void'($urandom(75));
        step(12, "reset");
        rst <= 1'b0;
        step(500, "full rate");
        check({8'h00, trk, roe}, 10'h003);
        lpb <= 1'b1;
        step(500, "loopback");
        check({8'h00, trk, soe}, 10'h002);
        aln <= 1'b0;
        step(200, "align off");
        aln <= 1'b1;
        rst <= 1'b1;
        rsel <= 1'b0;
        step(3, "second reset");
        rst <= 1'b0;
        lpb <= 1'b0;
        step(600, "half rate");
        check({9'h000, trk}, 10'h001);
        prbs <= 1'b1;
        aln <= 1'b0;
        step(100, "prbs start");
        pchk <= 1'b1;
        step(200, "prbs pass");
        check({9'h000, flag}, 10'h001);
        flip <= 1'b1;
        step(1, "error one");
        flip <= 1'b0;
        step(200, "prbs normal");
        check({8'h00, flag, low}, 10'h003);
        aln <= 1'b1;
        step(100, "latched mode");
        flip <= 1'b1;
        step(1, "error two");
        flip <= 1'b0;
        step(300, "prbs latched");
        check({9'h000, flag}, 10'h000);
        en <= 1'b0;
        pchk <= 1'b0;
        step(6, "disable");
        check({8'h00, roe, soe}, 10'h000);
        give_verdict;
    end
    initial begin
        #200000;
        err_total++;
        give_verdict;
    end
endmodule // tbi_serdes_core_tb
`default_nettype wire
